//--- hw/ssar_pkg.sv
// Shared constants for the serial converter readout link: frame layout and host timing.
// Assumes a 125 MHz host clock; the converter end runs only on the serial clock.
package ssar_pkg;
   // Frame layout
   localparam int unsigned FRAME_EDGES = 16;
   localparam int unsigned RES_BITS = 12;
   localparam int unsigned LEAD_ZEROS = FRAME_EDGES - RES_BITS;
   localparam int unsigned HOLD_EDGE = 3;
   localparam int unsigned EDGE_W = 5;

   // Host clock and link timing, each time in its printed unit
   localparam int unsigned CLK_PERIOD_NS = 8;
   localparam int unsigned SCLK_MAX_KHZ = 3400;
   localparam int unsigned QUIET_MIN_NS = 10;
   localparam int unsigned THROUGHPUT_MAX_KSPS = 200;

   // Least times round up to whole host cycles
   localparam int unsigned SCLK_HALF_CYC =
      (1000000 + 2 * SCLK_MAX_KHZ * CLK_PERIOD_NS - 1) / (2 * SCLK_MAX_KHZ * CLK_PERIOD_NS);
   localparam int unsigned QUIET_CYC = (QUIET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned FRAME_MIN_NS = 1000000 / THROUGHPUT_MAX_KSPS;
   localparam int unsigned FRAME_MIN_CYC = (FRAME_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned DIV_W = 8;
   localparam int unsigned PER_W = 10;
endpackage

//--- hw/ssar_link_if.sv
// Three-wire link between host and converter: frame select, serial clock, serial result.
// The result wire is resolved here from the converter's output enable.
`timescale 1ns/1ns
interface ssar_link_if;
   logic sclk;
   logic cs_n;
   logic serial_result_out;
   logic serial_result_oe;
   wire serial_result_line;

   // Released line shows the inverse of serial_result_out, which is low once released, so a late sample reads high
   assign serial_result_line = serial_result_oe ? serial_result_out : ~serial_result_out;

   modport dev (
      input sclk,
      input cs_n,
      output serial_result_out,
      output serial_result_oe
   );

   modport host (
      output sclk,
      output cs_n,
      input serial_result_line
   );
endinterface

//--- hw/ssar_dev.sv
// Converter end of the readout link, clocked only by the serial clock from the host.
// Assumes the host idles the serial clock high and keeps frame select high between frames.
// What this block does, and the host duties it relies on (R8, R12, R13)
// R1: New conversion starts when frame select falls
// R2: Conversion stepped only by serial clock edges
// R3: Frame spans sixteen serial clock cycles
// R4: Frame returns its own sample, no latency
// R5: Powers down by itself after conversion
// R6: Result has twelve bits
// R7: Result is straight unsigned binary
// R8: Host keeps serial clock slow, balanced duty
// R9: Output starts driving as frame select falls
// R10: Output bits change after falling edges
// R11: Output released after last falling edge
// R12: Host waits quiet time before next frame
// R13: Host limits frame rate to throughput
// R14: Four zeros then twelve bits, MSB first
// R15: Frame select triggers and brackets transfer
// R16: Track until third falling edge, then hold
// R17: Stay powered down until next frame
`timescale 1ns/1ns
module ssar_dev
   import ssar_pkg::*;
(
   // Link
   ssar_link_if.dev link,
   // Converter side
   input wire logic [RES_BITS-1:0] ANALOG_IN,
   output logic AWAKE
);
   typedef enum logic [3:0] {
      ST_PDOWN = 4'h1,
      ST_TRACK = 4'h2,
      ST_CONV = 4'h4,
      ST_DONE = 4'h8
   } ssar_dev_state_type;

   ssar_dev_state_type state_q, state_d;
   logic [EDGE_W-1:0] edge_q, edge_d;
   logic [RES_BITS-1:0] hold_q, hold_d;
   logic bit_q, bit_d;

   always_comb begin
      state_d = state_q;
      edge_d = edge_q;
      hold_d = hold_q;
      bit_d = 1'b0;
      if (edge_q != EDGE_W'(FRAME_EDGES)) begin
         edge_d = edge_q + 1'b1; // R2
      end
      case (state_q)
         ST_PDOWN: begin
            state_d = ST_TRACK; // R1
         end
         ST_TRACK: begin
            if (edge_d == EDGE_W'(HOLD_EDGE)) begin
               // Input is tracked until here, so the held value is this frame's sample
               hold_d = ANALOG_IN; // R16 R4 R6 R7
               state_d = ST_CONV;
            end
         end
         ST_CONV: begin
            if (edge_d == EDGE_W'(FRAME_EDGES)) begin
               state_d = ST_DONE; // R3 R5
            end else if (edge_d >= EDGE_W'(LEAD_ZEROS)) begin
               bit_d = hold_q[4'(5'(FRAME_EDGES - 1) - edge_d)]; // R14 R10
            end
         end
         ST_DONE: begin
            state_d = ST_DONE; // R17
         end
         default: begin
            state_d = ST_PDOWN;
         end
      endcase
   end

   // Frame select high is the only reset this end has: it ends every frame
   always_ff @(negedge link.sclk or posedge link.cs_n) begin
      if (link.cs_n) begin
         state_q <= ST_PDOWN; // R15 R17
         edge_q <= '0;
         hold_q <= '0;
         bit_q <= 1'b0;
      end else begin
         state_q <= state_d;
         edge_q <= edge_d;
         hold_q <= hold_d;
         bit_q <= bit_d;
      end
   end

   // Leading zero is on the line as soon as frame select falls
   assign link.serial_result_out = bit_q; // R14
   assign link.serial_result_oe = ~link.cs_n & (state_q != ST_DONE); // R9 R11
   assign AWAKE = ~link.cs_n & (state_q != ST_DONE); // R5
endmodule // ssar_dev

//--- hw/ssar_host.sv
// Host end of the readout link: makes frame select and the serial clock, collects results.
// Assumes a 125 MHz clock; the serial clock is divided down from it and driven out.
`timescale 1ns/1ns
module ssar_host
   import ssar_pkg::*;
(
   // Clock and reset
   input wire logic CLK,
   input wire logic ARST_N,
   // Link
   ssar_link_if.host link,
   // Request
   input wire logic START,
   output logic BUSY,
   // Result
   output logic [RES_BITS-1:0] RESULT_DATA,
   output logic [LEAD_ZEROS-1:0] RESULT_LEAD,
   output logic RESULT_VALID
);
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_SETUP = 5'h02,
      ST_LOW = 5'h04,
      ST_HIGH = 5'h08,
      ST_GAP = 5'h10
   } ssar_host_state_type;

   ssar_host_state_type state_q, state_d;
   logic [DIV_W-1:0] div_q, div_d;
   logic [PER_W-1:0] per_q, per_d;
   logic [EDGE_W-1:0] edge_q, edge_d;
   logic [FRAME_EDGES-1:0] shr_q, shr_d;
   logic [RES_BITS-1:0] data_q, data_d;
   logic [LEAD_ZEROS-1:0] lead_q, lead_d;
   logic valid_q, valid_d;
   logic sclk_q, sclk_d;
   logic cs_n_q, cs_n_d;
   logic sdo_s1_q, sdo_s2_q;
   logic half_end;

   assign half_end = (div_q == DIV_W'(SCLK_HALF_CYC - 1));

   always_comb begin
      state_d = state_q;
      div_d = div_q + 1'b1;
      per_d = (per_q == PER_W'(FRAME_MIN_CYC)) ? per_q : per_q + 1'b1;
      edge_d = edge_q;
      shr_d = shr_q;
      data_d = data_q;
      lead_d = lead_q;
      valid_d = 1'b0;
      sclk_d = sclk_q;
      cs_n_d = cs_n_q;
      case (state_q)
         ST_IDLE: begin
            div_d = '0;
            if (START) begin
               cs_n_d = 1'b0; // R15
               per_d = '0;
               edge_d = '0;
               state_d = ST_SETUP;
            end
         end
         ST_SETUP, ST_HIGH: begin
            if (half_end) begin
               // Bit is read just before the edge that makes the converter move on
               sclk_d = 1'b0; // R8
               div_d = '0;
               edge_d = edge_q + 1'b1;
               shr_d = {shr_q[FRAME_EDGES-2:0], sdo_s2_q}; // R10
               state_d = ST_LOW;
            end
         end
         ST_LOW: begin
            if (half_end) begin
               sclk_d = 1'b1; // R8
               div_d = '0;
               if (edge_q == EDGE_W'(FRAME_EDGES)) begin
                  cs_n_d = 1'b1; // R3
                  data_d = shr_q[RES_BITS-1:0];
                  lead_d = shr_q[FRAME_EDGES-1:RES_BITS];
                  valid_d = 1'b1;
                  state_d = ST_GAP;
               end else begin
                  state_d = ST_HIGH;
               end
            end
         end
         ST_GAP: begin
            if (div_q == DIV_W'(QUIET_CYC)) begin
               div_d = div_q;
               if (per_q == PER_W'(FRAME_MIN_CYC)) begin
                  state_d = ST_IDLE; // R12 R13
               end
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         state_q <= ST_IDLE;
         div_q <= '0;
         per_q <= '0;
         edge_q <= '0;
         shr_q <= '0;
         data_q <= '0;
         lead_q <= '0;
         valid_q <= 1'b0;
         sclk_q <= 1'b1;
         cs_n_q <= 1'b1;
         sdo_s1_q <= 1'b0;
         sdo_s2_q <= 1'b0;
      end else begin
         state_q <= state_d;
         div_q <= div_d;
         per_q <= per_d;
         edge_q <= edge_d;
         shr_q <= shr_d;
         data_q <= data_d;
         lead_q <= lead_d;
         valid_q <= valid_d;
         sclk_q <= sclk_d;
         cs_n_q <= cs_n_d;
         // The result line is driven from the serial clock domain
         sdo_s1_q <= link.serial_result_line;
         sdo_s2_q <= sdo_s1_q;
      end
   end

   assign link.sclk = sclk_q;
   assign link.cs_n = cs_n_q;
   assign BUSY = (state_q != ST_IDLE);
   assign RESULT_DATA = data_q;
   assign RESULT_LEAD = lead_q;
   assign RESULT_VALID = valid_q;
endmodule // ssar_host

//--- tb/ssar_link_monitor.sv
// Assertions on the three-wire link, all sampled on the host clock.
// Assumes the serial clock is divided from CLK, so its edges follow CLK edges.
`timescale 1ns/1ns
module ssar_link_monitor
   import ssar_pkg::*;
(
   // Host clock and reset
   input wire logic CLK,
   input wire logic ARST_N,
   // Link
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic serial_result_out,
   input wire logic serial_result_oe
);
   logic sclk_q;
   logic fall_now;
   logic [EDGE_W-1:0] fall_cnt_q;
   logic [EDGE_W-1:0] fall_cnt_d;
   // Count is current in the cycle of the fall, since the data bit moves with it
   always_comb begin
      fall_now = sclk_q & ~sclk;
      fall_cnt_d = cs_n ? 5'h00 : fall_cnt_q + {4'h0, fall_now};
   end
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         sclk_q <= 1'b1;
         fall_cnt_q <= 5'h00;
      end else begin
         sclk_q <= sclk;
         fall_cnt_q <= fall_cnt_d;
      end
   end
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!ARST_N);
   chk_drive_on_select: assert property ($fell(cs_n) |-> serial_result_oe && !serial_result_out)
      else $error("output not driven low at frame start");
   chk_idle_released: assert property (cs_n |-> !serial_result_oe)
      else $error("output driven outside frame");
   chk_sclk_idle: assert property (cs_n |-> sclk)
      else $error("serial clock low outside frame");
   chk_first_fall: assert property ($fell(cs_n) |-> ##19 $fell(sclk))
      else $error("first serial fall misplaced");
   chk_low_time: assert property (fall_now && !cs_n |-> ##19 $rose(sclk))
      else $error("serial clock low time wrong");
   chk_high_time: assert property ($rose(sclk) && !cs_n |-> ##19 $fell(sclk))
      else $error("serial clock high time wrong");
   chk_lead_zero: assert property (serial_result_oe && fall_cnt_d < 5'h04 |-> !serial_result_out)
      else $error("leading bit not zero");
   chk_bit_stable: assert property (serial_result_oe && $past(serial_result_oe) && !fall_now
      |-> $stable(serial_result_out))
      else $error("data changed without serial fall");
   chk_release_last: assert property (fall_cnt_d == 5'h10 |-> !serial_result_oe)
      else $error("output not released after last fall");
   chk_drive_mid: assert property (!cs_n && fall_cnt_d < 5'h10 |-> serial_result_oe)
      else $error("output dropped mid frame");
   chk_frame_edges: assert property ($rose(cs_n) |-> fall_cnt_q == 5'h10)
      else $error("frame not sixteen falls");
   chk_quiet_gap: assert property ($rose(cs_n) |-> cs_n [*2])
      else $error("frame select high too briefly");
endmodule // ssar_link_monitor

//--- tb/tb.sv
// Bench joining host and converter ends over one link, with the link checker beside it.
// Assumes the design package and interface are compiled first.
`timescale 1ns/1ns
module tb;
   import ssar_pkg::*;
   logic CLK;
   logic ARST_N;
   logic START;
   logic BUSY;
   logic RESULT_VALID;
   logic awake;
   logic [RES_BITS-1:0] RESULT_DATA;
   logic [RES_BITS-1:0] analog_in;
   logic [LEAD_ZEROS-1:0] RESULT_LEAD;
   int failures;
   int n_compared;
   ssar_link_if link();
   ssar_dev i_ssar_dev (.link(link), .ANALOG_IN(analog_in), .AWAKE(awake));
   ssar_host i_ssar_host (.CLK(CLK), .ARST_N(ARST_N), .link(link), .START(START),
      .BUSY(BUSY), .RESULT_DATA(RESULT_DATA), .RESULT_LEAD(RESULT_LEAD),
      .RESULT_VALID(RESULT_VALID));
   ssar_link_monitor i_ssar_link_monitor (.CLK(CLK), .ARST_N(ARST_N), .sclk(link.sclk),
      .cs_n(link.cs_n), .serial_result_out(link.serial_result_out),
      .serial_result_oe(link.serial_result_oe));
   task check(input logic [11:0] got, input logic [11:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task stop_test();
      if (failures == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Input moves after the first fall and again after the third: only the held value counts
   task frame(input logic [11:0] v);
      int n;
      time t_busy;
      analog_in = ~v;
      check({11'h000, link.serial_result_oe}, 12'h000);
      @(negedge CLK);
      START = 1'b1;
      n = 0;
      while (BUSY !== 1'b1 && n < 10) begin
         @(negedge CLK);
         n++;
      end
      t_busy = $time;
      check({11'h000, awake}, 12'h001);
      check({11'h000, link.serial_result_line}, 12'h000);
      // Held START while busy must not queue a second frame
      repeat (10) @(negedge CLK);
      START = 1'b0;
      @(negedge link.sclk);
      @(negedge CLK);
      analog_in = v;
      repeat (2) @(negedge link.sclk);
      @(negedge CLK);
      analog_in = ~v;
      n = 0;
      while (RESULT_VALID !== 1'b1 && n < 700) begin
         @(negedge CLK);
         n++;
      end
      check(RESULT_DATA, v);
      check({8'h00, RESULT_LEAD}, 12'h000);
      check({11'h000, awake}, 12'h000);
      // Host stays busy until the least frame period has run out
      n = 0;
      while (BUSY !== 1'b0 && n < 100) begin
         @(negedge CLK);
         n++;
      end
      check({11'h000, BUSY}, 12'h000);
      check({11'h000, ($time - t_busy) >= CLK_PERIOD_NS * FRAME_MIN_CYC}, 12'h001);
   endtask
   initial begin
      CLK = 1'b0;
      forever #4 CLK = ~CLK;
   end
   initial begin
      failures = 0;
      n_compared = 0;
      ARST_N = 1'b0;
      START = 1'b0;
      analog_in = 12'h000;
      repeat (16) @(negedge CLK);
      check({11'h000, BUSY}, 12'h000);
      ARST_N = 1'b1;
      frame(12'h000);
      frame(12'hfff);
      frame(12'ha5c);
      frame(12'h801);
      frame(12'h001);
      stop_test();
   end
   initial begin
      repeat (6000) @(posedge CLK);
      failures++;
      stop_test();
   end
endmodule // tb
